// file: design/hdl_judge.sv
// Per-channel limit comparison and contact judgment
`timescale 1ns/1ps
`default_nettype none
module hdl_judge (
  input  wire hdl_pkg::hdl_samp_s samp,
  input  wire logic [15:0]        hi_lim,
  input  wire logic [15:0]        lo_lim,
  input  wire logic [15:0]        cap_open,
  input  wire logic [15:0]        cap_adj,
  output hdl_pkg::hdl_chan_s      judge
);
  // Scaled terms; multiplying instead of dividing keeps the compare exact
  logic [27:0] cap_scaled;
  logic [27:0] lim_scaled;
  assign cap_scaled = 28'(samp.cap) * 28'(hdl_pkg::CONTACT_DIV);
  assign lim_scaled = 28'(cap_open) * 28'(hdl_pkg::CONTACT_MUL)
                    + (28'(hdl_pkg::CONTACT_ADD) + 28'(cap_adj)) * 28'(hdl_pkg::CONTACT_DIV);
  // Exactly one of high, pass, low
  assign judge.hi       = samp.value > hi_lim;
  assign judge.lo       = (samp.value < lo_lim) && !(samp.value > hi_lim);
  assign judge.pass     = !(samp.value > hi_lim) && !(samp.value < lo_lim);
  // Contact only above the limit
  assign judge.no_touch = !(cap_scaled > lim_scaled);
endmodule : hdl_judge
`default_nettype wire

// file: design/hdl_pkg.sv
// Package: constants, register map and carrier types for the handler result block
package hdl_pkg;
  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] STATE_OFS  = 8'h0C;
  localparam logic [7:0] HILIM_OFS  = 8'h10;
  localparam logic [7:0] LOLIM_OFS  = 8'h14;
  localparam logic [7:0] CAPOPN_OFS = 8'h18;
  localparam logic [7:0] CAPADJ_OFS = 8'h1C;
  // Control register fields
  localparam int CTRL_COMP_ON  = 0;
  localparam int CTRL_TRIG_EXT = 1;
  localparam int CTRL_SW_TRIG  = 2;
  localparam int CTRL_ERR_CLR  = 3;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int ADDR_W        = 5;
  localparam logic [4:0] ADDR_MAX   = 5'h1E;
  localparam logic [4:0] ADDR_RESET = 5'h11;
  // Status / mask bit positions
  localparam int EV_W       = 4;
  localparam int EV_INDEX   = 0;
  localparam int EV_EOM     = 1;
  localparam int EV_ALARM   = 2;
  localparam int EV_IGNORED = 3;
  // Error codes that halt operation and fire the fault pulse
  localparam logic [9:0] ERR_E11  = 10'h00B;
  localparam logic [9:0] ERR_E12  = 10'h00C;
  localparam logic [9:0] ERR_E13  = 10'h00D;
  localparam logic [9:0] ERR_E14  = 10'h00E;
  localparam logic [9:0] ERR_E15  = 10'h00F;
  localparam logic [9:0] ERR_E20  = 10'h014;
  localparam logic [9:0] ERR_E313 = 10'h139;
  // Fault pulse timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int FAULT_MS     = 200;
  localparam int FAULT_CYCLES = CLK_HZ / 1000 * FAULT_MS;
  // Contact limit: open * 1035/1000 + 40 (0.40 pF in 0.01 pF steps) + offset
  localparam logic [10:0] CONTACT_MUL = 11'h40B;
  localparam logic [10:0] CONTACT_DIV = 11'h3E8;
  localparam logic [15:0] CONTACT_ADD = 16'h0028;
  localparam int NCH = 4;
  // Sequencer states
  typedef enum logic [1:0] {
    HDL_IDLE = 2'b00,
    HDL_CONV = 2'b01,
    HDL_CALC = 2'b10
  } hdl_state_e;
  // One channel's converted reading and probe capacitance
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] cap;
  } hdl_samp_s;
  // One channel's judgment (active high inside the block)
  typedef struct packed {
    logic hi;
    logic pass;
    logic lo;
    logic no_touch;
  } hdl_chan_s;
endpackage : hdl_pkg

// file: design/hdl_pulse.sv
// Retriggerable one-shot of fixed length
`timescale 1ns/1ps
`default_nettype none
module hdl_pulse #(
  parameter int CYCLES = 2_000_000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] left;  // Cycles still to run
  // Load on fire, count down to zero; busy follows the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left <= '0;
      busy <= 1'b0;
    end
    else if (fire)
    begin
      left <= CW'(CYCLES - 1);
      busy <= 1'b1;
    end
    else if (left != '0)
      left <= left - CW'(1);
    else
      busy <= 1'b0;
  end
endmodule : hdl_pulse
`default_nettype wire

// file: design/hdl_top.sv
// Handler result signalling: sequencer, judgment outputs, fault pulse, APB registers
`timescale 1ns/1ps
`default_nettype none
module hdl_top #(
  parameter int FAULT_CYCLES = hdl_pkg::FAULT_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    irq,
  // Handler port, all active low
  input  wire logic               handler_start_n,
  input  wire logic               panel_freeze_n,
  output logic [3:0]              over_limit_n,
  output logic [3:0]              pass_n,
  output logic [3:0]              under_limit_n,
  output logic [3:0]              no_touch_n,
  output logic                    analog_done_n,
  output logic                    result_valid_n,
  output logic                    fault_n,
  // Converter side
  output logic                    conv_start,
  output logic [1:0]              conv_chan,
  input  wire logic               conv_done,
  input  wire hdl_pkg::hdl_samp_s conv_samp,
  // Instrument events and state
  input  wire logic               power_fail,
  input  wire logic               err_valid,
  input  wire logic [9:0]         err_code,
  output logic                    keys_disabled,
  output logic [4:0]              bus_addr
);
  // Software state
  logic                    comp_on;     // Comparator function enabled
  logic                    trig_ext;    // External trigger mode
  logic [15:0]             hi_lim;      // Upper limit
  logic [15:0]             lo_lim;      // Lower limit
  logic [15:0]             cap_open;    // Open-state capacitance
  logic [15:0]             cap_adj;     // User contact offset
  logic [3:0]              stat;        // Sticky events
  logic [3:0]              mask;        // Interrupt mask
  // Sequencer state
  hdl_pkg::hdl_state_e     state;
  logic [1:0]              chan;        // Channel being converted
  logic                    halted;      // Stopped by an error
  logic                    start_prev;  // Trigger pin last cycle
  hdl_pkg::hdl_chan_s [3:0] held;       // Judgments of the running cycle
  hdl_pkg::hdl_chan_s      judge;
  logic                    fault_busy;
  // Bus decode
  logic                    wr_acc;
  logic                    rd_acc;
  logic                    sw_trig;
  logic                    err_clr;
  logic                    err_hit;
  logic                    start_edge;
  logic                    trig;
  logic                    ev_index;
  logic                    ev_eom;
  logic                    ev_ignored;
  logic [3:0]              ev_all;

  assign wr_acc  = psel && penable && pready && pwrite;
  assign rd_acc  = psel && penable && pready && !pwrite;
  assign sw_trig = wr_acc && (paddr == hdl_pkg::CTRL_OFS) && pwdata[hdl_pkg::CTRL_SW_TRIG];
  assign err_clr = wr_acc && (paddr == hdl_pkg::CTRL_OFS) && pwdata[hdl_pkg::CTRL_ERR_CLR];

  // Listed error codes halt the sequencer and fire the fault pulse
  assign err_hit = err_valid && ((err_code == hdl_pkg::ERR_E11) || (err_code == hdl_pkg::ERR_E12)
                || (err_code == hdl_pkg::ERR_E13) || (err_code == hdl_pkg::ERR_E14)
                || (err_code == hdl_pkg::ERR_E15) || (err_code == hdl_pkg::ERR_E20)
                || (err_code == hdl_pkg::ERR_E313));

  // Pin rising edge in external mode; pins are already synchronous
  assign start_edge = trig_ext && handler_start_n && !start_prev;
  // No trigger while halted or with the comparator off
  assign trig       = (start_edge || sw_trig) && !halted && comp_on && !err_hit
                   && (state == hdl_pkg::HDL_IDLE);
  assign ev_ignored = start_edge && halted;
  assign ev_index   = (state == hdl_pkg::HDL_CONV) && conv_done && (chan == 2'(hdl_pkg::NCH - 1)) && !err_hit;
  assign ev_eom     = (state == hdl_pkg::HDL_CALC) && !err_hit;
  assign ev_all     = {ev_ignored, err_hit || power_fail, ev_eom, ev_index};

  // Judgment of the channel now delivering data
  hdl_judge u_judge (
    .samp     (conv_samp),
    .hi_lim   (hi_lim),
    .lo_lim   (lo_lim),
    .cap_open (cap_open),
    .cap_adj  (cap_adj),
    .judge    (judge)
  );

  // Fixed-length fault pulse
  hdl_pulse #(
    .CYCLES (FAULT_CYCLES)
  ) u_fault (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (power_fail || err_hit),
    .busy    (fault_busy)
  );

  // Trigger pin history; reset to idle-high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_prev <= 1'b1;
    else
      start_prev <= handler_start_n;
  end

  // Halt flag: an error stops operation until software clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted <= 1'b0;
    else if (err_hit)
      halted <= 1'b1;
    else if (err_clr)
      halted <= 1'b0;
  end

  // Four-channel sequencer; a failed contact does not abort it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= hdl_pkg::HDL_IDLE;
      chan       <= 2'h0;
      conv_start <= 1'b0;
      held       <= '0;
    end
    else if (err_hit)
    begin
      // Abandon the cycle; outputs keep their last values
      state      <= hdl_pkg::HDL_IDLE;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      case (state)
        hdl_pkg::HDL_IDLE:
        begin
          if (trig)
          begin
            state      <= hdl_pkg::HDL_CONV;
            chan       <= 2'h0;
            conv_start <= 1'b1;
          end
        end
        hdl_pkg::HDL_CONV:
        begin
          if (conv_done)
          begin
            held[chan] <= judge;
            if (chan == 2'(hdl_pkg::NCH - 1))
              state <= hdl_pkg::HDL_CALC;
            else
            begin
              chan       <= chan + 2'h1;
              conv_start <= 1'b1;
            end
          end
        end
        hdl_pkg::HDL_CALC:
          state <= hdl_pkg::HDL_IDLE;
        default:
          state <= hdl_pkg::HDL_IDLE;
      endcase
    end
  end

  // Converter channel select follows the sequencer
  assign conv_chan = chan;

  // Done and valid: cleared at cycle start, index before eom
  // Gated off (high) with the comparator off; frozen while halted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      analog_done_n  <= 1'b1;
      result_valid_n <= 1'b1;
    end
    else if (!comp_on)
    begin
      analog_done_n  <= 1'b1;
      result_valid_n <= 1'b1;
    end
    else if (trig)
    begin
      analog_done_n  <= 1'b1;
      result_valid_n <= 1'b1;
    end
    else
    begin
      if (ev_index)
        analog_done_n <= 1'b0;
      // Valid only after every judgment has been stored
      if (ev_eom)
        result_valid_n <= 1'b0;
    end
  end

  // Judgment pins, active low, loaded with result-valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      over_limit_n  <= 4'hF;
      pass_n        <= 4'hF;
      under_limit_n <= 4'hF;
      no_touch_n    <= 4'hF;
    end
    else if (!comp_on)
    begin
      over_limit_n  <= 4'hF;
      pass_n        <= 4'hF;
      under_limit_n <= 4'hF;
      no_touch_n    <= 4'hF;
    end
    else if (ev_eom)
    begin
      for (int i = 0; i < hdl_pkg::NCH; i++)
      begin
        over_limit_n[i]  <= !held[i].hi;
        pass_n[i]        <= !held[i].pass;
        under_limit_n[i] <= !held[i].lo;
        no_touch_n[i]    <= !held[i].no_touch;
      end
    end
  end

  // Fault pin and panel lockout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_n       <= 1'b1;
      keys_disabled <= 1'b0;
    end
    else
    begin
      fault_n       <= !(fault_busy && comp_on);
      keys_disabled <= !panel_freeze_n;
    end
  end

  // Control and limit registers; an address above 30 is refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comp_on  <= 1'b0;
      trig_ext <= 1'b0;
      bus_addr <= hdl_pkg::ADDR_RESET;
      hi_lim   <= 16'hFFFF;
      lo_lim   <= 16'h0000;
      cap_open <= 16'h0000;
      cap_adj  <= 16'h0000;
      mask     <= 4'h0;
    end
    else if (wr_acc)
    begin
      if (paddr == hdl_pkg::CTRL_OFS)
      begin
        comp_on  <= pwdata[hdl_pkg::CTRL_COMP_ON];
        trig_ext <= pwdata[hdl_pkg::CTRL_TRIG_EXT];
        if (pwdata[hdl_pkg::CTRL_ADDR_LSB +: hdl_pkg::ADDR_W] <= hdl_pkg::ADDR_MAX)
          bus_addr <= pwdata[hdl_pkg::CTRL_ADDR_LSB +: hdl_pkg::ADDR_W];
      end
      else if (paddr == hdl_pkg::MASK_OFS)
        mask <= pwdata[hdl_pkg::EV_W-1:0];
      else if (paddr == hdl_pkg::HILIM_OFS)
        hi_lim <= pwdata[15:0];
      else if (paddr == hdl_pkg::LOLIM_OFS)
        lo_lim <= pwdata[15:0];
      else if (paddr == hdl_pkg::CAPOPN_OFS)
        cap_open <= pwdata[15:0];
      else if (paddr == hdl_pkg::CAPADJ_OFS)
        cap_adj <= pwdata[15:0];
    end
  end

  // Sticky events; a read clears them but a same-cycle event survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat <= 4'h0;
    else if (rd_acc && (paddr == hdl_pkg::STAT_OFS))
      stat <= ev_all;
    else
      stat <= stat | ev_all;
  end

  // Interrupt line from unmasked sticky bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat & mask);
  end

  // APB answer: one access cycle, registered data and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (paddr == hdl_pkg::CTRL_OFS)
          prdata <= {19'h0_0000, bus_addr, 6'h00, trig_ext, comp_on};
        else if (paddr == hdl_pkg::STAT_OFS)
          prdata <= {28'h000_0000, stat | ev_all};
        else if (paddr == hdl_pkg::MASK_OFS)
          prdata <= {28'h000_0000, mask};
        else if (paddr == hdl_pkg::STATE_OFS)
          prdata <= {24'h00_0000, keys_disabled, halted, chan, 2'h0, state};
        else if (paddr == hdl_pkg::HILIM_OFS)
          prdata <= {16'h0000, hi_lim};
        else if (paddr == hdl_pkg::LOLIM_OFS)
          prdata <= {16'h0000, lo_lim};
        else if (paddr == hdl_pkg::CAPOPN_OFS)
          prdata <= {16'h0000, cap_open};
        else if (paddr == hdl_pkg::CAPADJ_OFS)
          prdata <= {16'h0000, cap_adj};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // Cycle counter for the fault pulse length check
  logic [31:0] low_run;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_run <= 32'h0000_0000;
    else
      low_run <= fault_n ? 32'h0000_0000 : low_run + 32'h0000_0001;
  end

  fault_fires_a: assert property (@(posedge pclk) disable iff (!presetn)
    (comp_on && err_hit) |=> ##1 !fault_n) else $error("fault pin missed an error");
  fault_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_run <= 32'(FAULT_CYCLES)) else $error("fault pulse too long");
  done_before_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    !result_valid_n |-> !analog_done_n) else $error("valid without done");
  index_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_index && comp_on) |=> !analog_done_n) else $error("done not asserted");
  valid_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(result_valid_n) |-> $past(state) == hdl_pkg::HDL_CALC) else $error("valid without calc");
  one_of_three_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!result_valid_n) |-> ((~over_limit_n) ^ (~pass_n) ^ (~under_limit_n)) == 4'hF)
    else $error("judgment not one-hot");
  halt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halted && comp_on && $past(comp_on)) |-> $stable(pass_n) && $stable(result_valid_n))
    else $error("outputs moved while halted");
  halt_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    halted |-> !trig) else $error("trigger taken while halted");
  comp_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(comp_on) |-> (result_valid_n && analog_done_n && pass_n == 4'hF)) else $error("output while off");
  addr_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_addr <= hdl_pkg::ADDR_MAX) else $error("bus address above 30");
  four_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == hdl_pkg::HDL_CALC) |-> chan == 2'(hdl_pkg::NCH - 1)) else $error("channel sweep short");
  full_cycle_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(result_valid_n));
  fault_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(fault_n));
  ignored_c: cover property (@(posedge pclk) disable iff (!presetn) ev_ignored);
endmodule : hdl_top
`default_nettype wire

// file: test/hdl_handler_model.sv
// Handler machine model: trigger pulses, panel lock and judgment capture
`timescale 1ns/1ps
`default_nettype none
module hdl_handler_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        trig_req,        // Ask for one trigger pulse
  input  wire logic        lock_req,        // Ask for panel lock
  input  wire logic        result_valid_n,
  input  wire logic [15:0] judge_n,         // Over, pass, under, no-touch pins
  output logic             handler_start_n,
  output logic             panel_freeze_n,
  output logic [15:0]      seen_judge       // Pins as taken at result valid
);
  int   low_left;  // Cycles of low pulse still to run
  logic valid_q;   // Result-valid pin one cycle ago
  // Low pulse of 12 cycles, above the 1 us minimum; the start is its rising end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_left <= 0;
      handler_start_n <= 1'b1;
    end
    else if (trig_req)
    begin
      low_left <= 12;
      handler_start_n <= 1'b0;
    end
    else if (low_left > 0)
    begin
      low_left <= low_left - 1;
      handler_start_n <= (low_left == 1);
    end
  end
  // Lock is a plain level; results are taken only when valid falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      panel_freeze_n <= 1'b1;
      valid_q <= 1'b1;
      seen_judge <= 16'h0000;
    end
    else
    begin
      panel_freeze_n <= !lock_req;
      valid_q <= result_valid_n;
      if (!result_valid_n && valid_q)
        seen_judge <= judge_n;
    end
  end
endmodule : hdl_handler_model
`default_nettype wire

// file: test/test_handler_result_signalling.sv
// Testbench for the handler result block: APB tasks, converter stub, handler model
`timescale 1ns/1ps
`default_nettype none
module test_handler_result_signalling;
  localparam int FC = 20;  // Short fault pulse to keep the run brief
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic handler_start_n, panel_freeze_n, analog_done_n, result_valid_n, fault_n;
  logic [3:0]  over_limit_n, pass_n, under_limit_n, no_touch_n;
  logic conv_start, conv_done, power_fail, err_valid, keys_disabled, trig_req, lock_req;
  logic [1:0]  conv_chan;
  logic [9:0]  err_code;
  logic [4:0]  bus_addr;
  logic [15:0] seen_judge;
  hdl_pkg::hdl_samp_s conv_samp;
  int mismatches, num_checks, n_start, cd;
  // Per-channel samples {value, cap}: high, pass, low, pass with poor contact
  logic [31:0] tab [4] = '{32'h00C8_00C8, 32'h004B_00C8, 32'h000A_00C8, 32'h004B_0064};
  // All error codes that must halt and fire the fault pulse
  logic [9:0] codes [7] = '{hdl_pkg::ERR_E11, hdl_pkg::ERR_E12, hdl_pkg::ERR_E13,
    hdl_pkg::ERR_E14, hdl_pkg::ERR_E15, hdl_pkg::ERR_E20, hdl_pkg::ERR_E313};
  hdl_top #(.FAULT_CYCLES(FC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .handler_start_n(handler_start_n),
    .panel_freeze_n(panel_freeze_n), .over_limit_n(over_limit_n), .pass_n(pass_n),
    .under_limit_n(under_limit_n), .no_touch_n(no_touch_n), .analog_done_n(analog_done_n),
    .result_valid_n(result_valid_n), .fault_n(fault_n), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_samp(conv_samp),
    .power_fail(power_fail), .err_valid(err_valid), .err_code(err_code),
    .keys_disabled(keys_disabled), .bus_addr(bus_addr));
  hdl_handler_model handler (.pclk(pclk), .presetn(presetn), .trig_req(trig_req),
    .lock_req(lock_req), .result_valid_n(result_valid_n),
    .judge_n({over_limit_n, pass_n, under_limit_n, no_touch_n}),
    .handler_start_n(handler_start_n), .panel_freeze_n(panel_freeze_n), .seen_judge(seen_judge));
  // 10 MHz clock
  always #50 pclk = ~pclk;
  // Converter stub: done three cycles after each start; data toggles outside it
  always @(posedge pclk)
  begin
    conv_done <= 1'b0;
    conv_samp <= hdl_pkg::hdl_samp_s'(~conv_samp);
    if (conv_start)
    begin
      n_start <= n_start + 1;
      cd <= 3;
    end
    else if (cd == 1)
    begin
      conv_done <= 1'b1;
      conv_samp <= hdl_pkg::hdl_samp_s'(tab[conv_chan]);
      cd <= 0;
    end
    else if (cd > 1)
      cd <= cd - 1;
  end
  // Verdict and end of run
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Compare one value
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  // Bounded wait for result valid to reach a level
  task wv(input logic lvl);
    int n;
    n = 0;
    while (result_valid_n !== lvl && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
    begin
      mismatches++;
      stop_test();
    end
  endtask : wv
  // One measurement by software or by the handler pin
  task run(input logic ext, input logic [15:0] expw);
    int s0;
    s0 = n_start;
    if (ext)
    begin
      trig_req <= 1'b1;
      @(posedge pclk);
      trig_req <= 1'b0;
    end
    else
      apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E05);
    wv(1'b1);
    wv(1'b0);
    chk(analog_done_n, 1'b0);
    chk(n_start - s0, 32'h4);
    repeat (2) @(posedge pclk);
    chk(seen_judge, expw);
  endtask : run
  // Fire a fault source and measure the fault pulse
  task fault(input logic pf, input logic [9:0] code, input int len);
    int w, n;
    w = 0;
    n = 0;
    power_fail <= pf;
    err_valid <= !pf;
    err_code <= code;
    @(posedge pclk);
    power_fail <= 1'b0;
    err_valid <= 1'b0;
    while (fault_n !== 1'b0 && w < 10)
    begin
      @(posedge pclk);
      w++;
    end
    while (fault_n === 1'b0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n, len);
    if (n >= 100)
      stop_test();
  endtask : fault
  // Main sequence
  initial
  begin
    int s0;
    {pclk, presetn, psel, penable, pwrite, power_fail, err_valid, trig_req, lock_req} = '0;
    {paddr, pwdata, err_code, n_start, cd, mismatches, num_checks} = '0;
    conv_samp = '0;
    conv_done = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({over_limit_n, pass_n, under_limit_n, no_touch_n, analog_done_n, result_valid_n, fault_n},
        32'h7_FFFF);
    chk(bus_addr, 32'h11);
    apb(1'b0, hdl_pkg::HILIM_OFS, 32'h0);
    chk(r, 32'hFFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E01);
    apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1F01);
    @(posedge pclk);
    chk(bus_addr, 32'h1E);
    apb(1'b1, hdl_pkg::HILIM_OFS, 32'h64);
    apb(1'b1, hdl_pkg::LOLIM_OFS, 32'h32);
    apb(1'b1, hdl_pkg::CAPOPN_OFS, 32'h64);
    apb(1'b1, hdl_pkg::MASK_OFS, 32'h2);
    run(1'b0, 16'hE5B7);
    chk(irq, 1'b1);
    apb(1'b0, hdl_pkg::STAT_OFS, 32'h0);
    chk(r, 32'h3);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    // Contact limit at its boundary: equal is no contact, one below is contact
    apb(1'b1, hdl_pkg::CAPOPN_OFS, 32'h0);
    apb(1'b1, hdl_pkg::CAPADJ_OFS, 32'hA0);
    apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E03);
    run(1'b1, 16'hE5B0);
    apb(1'b1, hdl_pkg::CAPADJ_OFS, 32'h9F);
    run(1'b0, 16'hE5B7);
    apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E03);
    // Each halting error: pulse length, frozen pins, trigger ignored
    for (int i = 0; i < 7; i++)
    begin
      s0 = n_start;
      fault(1'b0, codes[i], FC);
      trig_req <= 1'b1;
      @(posedge pclk);
      trig_req <= 1'b0;
      repeat (20) @(posedge pclk);
      chk(n_start - s0, 32'h0);
      chk({over_limit_n, pass_n, under_limit_n, no_touch_n, analog_done_n, result_valid_n},
          {16'hE5B7, 2'b00});
      apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E0B);
    end
    apb(1'b0, hdl_pkg::STAT_OFS, 32'h0);
    chk(r & 32'h8, 32'h8);
    fault(1'b0, 10'h001, 0);
    fault(1'b1, 10'h000, FC);
    lock_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(keys_disabled, 1'b1);
    lock_req <= 1'b0;
    apb(1'b1, hdl_pkg::CTRL_OFS, 32'h0000_1E08);
    repeat (2) @(posedge pclk);
    chk({over_limit_n, pass_n, under_limit_n, no_touch_n, analog_done_n, result_valid_n},
        32'h3_FFFF);
    stop_test();
  end
endmodule : test_handler_result_signalling
`default_nettype wire
